//--- design/interval_rtc_consts.vh
// Constants for the periodic interval clock block
`ifndef INTERVAL_RTC_CONSTS_VH
`define INTERVAL_RTC_CONSTS_VH
// ****************************************
// Register indices; byte address is four times the index
// ****************************************
`define IDX_GATE 12'h0f76
`define IDX_CTRL 12'h0fc8
`define IDX_IRQ_STATUS 12'h0f80
`define IDX_IRQ_CLEAR 12'h0f84
`define IDX_IRQ_ENABLE 12'h0f88
`define ADDR_GATE {`IDX_GATE, 2'b00}
`define ADDR_CTRL {`IDX_CTRL, 2'b00}
`define ADDR_IRQ_STATUS {`IDX_IRQ_STATUS, 2'b00}
`define ADDR_IRQ_CLEAR {`IDX_IRQ_CLEAR, 2'b00}
`define ADDR_IRQ_ENABLE {`IDX_IRQ_ENABLE, 2'b00}
// ****************************************
// Field positions and reset values
// ****************************************
`define GATE_EN_BIT 5
`define CTRL_RUN_BIT 0
`define CTRL_SEL_LSB 1
`define CTRL_SEL_MSB 3
`define GATE_RESET 8'h00
`define CTRL_RESET 8'h00
`define CNT_WIDTH 15
`define SEL_BASE_EXP 15
`endif

//--- design/level_sync3.v
// Three-stage synchroniser with agreement check
`default_nettype none
module level_sync3
(
   input wire ref_clk,
   input wire rst_n,
   input wire async_in,
   output reg sync_out
);
   reg stage1;
   reg stage2;
   reg stage3;
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         // Change accepted only once two later stages agree
         if (stage2 == stage3)
         begin
            sync_out <= stage3;
         end
      end
   end
endmodule
`default_nettype wire

//--- design/interval_rtc.v
// Periodic interval interrupt generator with APB registers
// ****************************************
// ****************************************
//
// Implementation choice: the APB slave port.
`include "interval_rtc_consts.vh"
`default_nettype none
module interval_rtc
(
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [13:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire low_freq_clk,
   input wire low_freq_osc_enable,
   input wire stop_mode,
   input wire deep_sleep_zero,
   output reg interval_irq,
   output wire irq
);
   // ****************************************
   // Register state
   // ****************************************
   reg [7:0] power_gate_register;
   reg run_bit;
   reg [2:0] interval_select;
   reg [`CNT_WIDTH-1:0] counter;
   reg lf_prev;
   reg irq_status;
   reg irq_enable;
   wire lf_sync;
   wire osc_sync;
   wire stop_sync;
   wire sleep_sync;
   wire clock_gate_enable;
   wire wr_access;
   wire lf_rise;
   wire sel_gate;
   wire sel_ctrl;
   wire sel_status;
   wire sel_clear;
   wire sel_enable;
   wire setup_rd;
   wire [`CNT_WIDTH-1:0] sel_mask;
   // Next-state values
   reg [31:0] next_prdata;
   reg [7:0] next_power_gate_register;
   reg next_run_bit;
   reg [2:0] next_interval_select;
   reg [`CNT_WIDTH-1:0] next_count;
   reg next_pulse;
   reg next_irq_status;
   reg next_irq_enable;
   wire force_stop;
   wire [`CNT_WIDTH-1:0] next_counter;
   wire period_done;

   assign clock_gate_enable = power_gate_register[`GATE_EN_BIT];
   assign wr_access = psel & penable & pwrite;
   // Single-cycle access; no wait states needed
   assign pready = 1'b1;
   // Unmapped or refused writes raise no error
   assign pslverr = 1'b0;

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Pins cross into ref_clk through four flops
   level_sync3 u_sync_lf
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(low_freq_clk),
      .sync_out(lf_sync)
   );

   level_sync3 u_sync_osc
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(low_freq_osc_enable),
      .sync_out(osc_sync)
   );

   level_sync3 u_sync_stop
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(stop_mode),
      .sync_out(stop_sync)
   );

   level_sync3 u_sync_sleep
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(deep_sleep_zero),
      .sync_out(sleep_sync)
   );

   // Word match shared by read and write paths
   function hit;
      input [13:0] addr;
      input [11:0] index;
      begin
         hit = (addr[13:2] == index);
      end
   endfunction

   // ****************************************
   // Register decode
   // ****************************************
   assign sel_gate = hit(paddr, `IDX_GATE);
   assign sel_ctrl = hit(paddr, `IDX_CTRL);
   assign sel_status = hit(paddr, `IDX_IRQ_STATUS);
   assign sel_clear = hit(paddr, `IDX_IRQ_CLEAR);
   assign sel_enable = hit(paddr, `IDX_IRQ_ENABLE);
   // Read data is captured in the setup cycle
   assign setup_rd = psel & ~penable & ~pwrite;

   // ****************************************
   // Period mask
   // ****************************************
   // Bit i counts toward the period while i < 15 - select
   genvar i;
   generate
      for (i = 0; i < `CNT_WIDTH; i = i + 1)
      begin : g_mask
         assign sel_mask[i] = (i + interval_select < `SEL_BASE_EXP);
      end
   endgenerate

   assign force_stop = ~osc_sync | stop_sync | sleep_sync;
   // Edge detector idles low like the pin after reset
   // Gated base clock
   assign lf_rise = lf_sync & ~lf_prev & clock_gate_enable;
   assign next_counter = counter + {{(`CNT_WIDTH-1){1'b0}}, 1'b1};
   assign period_done =
      ((next_counter & sel_mask) == {`CNT_WIDTH{1'b0}});

   // ****************************************
   // Gate register
   // ****************************************
   // All bits stored; only the gate bit acts here
   always @*
   begin
      next_power_gate_register = power_gate_register;
      if (wr_access && sel_gate)
      begin
         next_power_gate_register = pwdata[7:0];
      end
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power_gate_register <= `GATE_RESET;
      end
      else
      begin
         power_gate_register <= next_power_gate_register;
      end
   end

   // ****************************************
   // Control register
   // ****************************************
   // Next control state; a forced halt beats a same-cycle write
   always @*
   begin
      next_run_bit = run_bit;
      next_interval_select = interval_select;
      if (force_stop)
      begin
         next_run_bit = 1'b0;
      end
      // Control writes are dropped while the gate bit is clear
      else if (wr_access && sel_ctrl && clock_gate_enable)
      begin
         next_run_bit = pwdata[`CTRL_RUN_BIT];
         if (!run_bit && pwdata[`CTRL_RUN_BIT])
         begin
            next_interval_select = pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_bit <= 1'b0;
         interval_select <= 3'h0;
      end
      else
      begin
         run_bit <= next_run_bit;
         interval_select <= next_interval_select;
      end
   end

   // ****************************************
   // Binary counter and interrupt pulse
   // ****************************************
   // Next count and pulse; the count runs on past each rollover
   always @*
   begin
      next_count = counter;
      next_pulse = 1'b0;
      if (!run_bit)
      begin
         next_count = {`CNT_WIDTH{1'b0}};
      end
      else if (lf_rise)
      begin
         next_count = next_counter;
         next_pulse = period_done;
      end
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lf_prev <= 1'b0;
         counter <= {`CNT_WIDTH{1'b0}};
         interval_irq <= 1'b0;
      end
      else
      begin
         lf_prev <= lf_sync;
         counter <= next_count;
         interval_irq <= next_pulse;
      end
   end

   // ****************************************
   // Interrupt status, clear and enable
   // ****************************************
   // Set beats a clear in the same cycle
   always @*
   begin
      next_irq_status = irq_status;
      next_irq_enable = irq_enable;
      if (interval_irq)
      begin
         next_irq_status = 1'b1;
      end
      else if (wr_access && sel_clear && pwdata[0])
      begin
         next_irq_status = 1'b0;
      end
      if (wr_access && sel_enable)
      begin
         next_irq_enable = pwdata[0];
      end
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_status <= 1'b0;
         irq_enable <= 1'b0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq_enable <= next_irq_enable;
      end
   end

   assign irq = irq_status & irq_enable;

   // ****************************************
   // Read data
   // ****************************************
   // Read mux; unmapped words read as zero
   // Clear register is write-only and reads zero
   always @*
   begin
      next_prdata = 32'h0000_0000;
      if (sel_gate)
      begin
         next_prdata = {24'h00_0000, power_gate_register};
      end
      else if (sel_ctrl)
      begin
         next_prdata = {28'h000_0000, interval_select, run_bit};
      end
      else if (sel_status)
      begin
         next_prdata = {31'h0000_0000, irq_status};
      end
      else if (sel_enable)
      begin
         next_prdata = {31'h0000_0000, irq_enable};
      end
   end

   // Loaded in setup so data stands through the access cycle
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (setup_rd)
      begin
         prdata <= next_prdata;
      end
   end
endmodule
`default_nettype wire

//--- tb/interval_rtc_checker.sv
// Port checks for the interval clock block
`default_nettype none
`include "interval_rtc_consts.vh"
module interval_rtc_checker
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic low_freq_clk,
   input wire logic low_freq_osc_enable,
   input wire logic stop_mode,
   input wire logic deep_sleep_zero,
   input wire logic interval_irq,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] edges;
   logic acc;
   assign acc = psel && penable;
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ****
   // Raw slow edges since last pulse
   // ****
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         edges <= 16'h0000;
      else if (interval_irq)
         edges <= 16'h0000;
      else if ($rose(low_freq_clk))
         edges <= edges + 16'h0001;
   end
   AST_PULSE: assert property (interval_irq |=> !interval_irq)
      else $error("interval pulse too long");
   AST_SPACING: assert property (interval_irq |-> edges >= 16'h00ff)
      else $error("interval pulses too close");
   AST_HALT: assert property (
      (stop_mode || deep_sleep_zero || !low_freq_osc_enable) [*8]
      |-> !interval_irq) else $error("pulse while halted");
   AST_CAUSE: assert property ($rose(irq) |->
      $past(interval_irq) || $past(acc && pwrite)) else $error("stray irq");
   AST_STICKY: assert property (irq && !(acc && pwrite) |=> irq)
      else $error("irq dropped by itself");
   AST_CTRL_RD: assert property (
      acc && !pwrite && paddr == `ADDR_CTRL |-> prdata[31:4] == 28'h0)
      else $error("control read has stray bits");
   AST_GATE_RD: assert property (
      acc && !pwrite && paddr == `ADDR_GATE |-> prdata[31:8] == 24'h0)
      else $error("gate read has stray bits");
   AST_RESET: assert property ($rose(rst_n) |-> !irq && !interval_irq)
      else $error("irq active after reset");
   cover property (interval_irq);
   cover property (irq);
   cover property (acc && pwrite && paddr == `ADDR_CTRL);
endmodule
`default_nettype wire

//--- tb/interval_rtc_tb.sv
// Self-checking bench for the interval clock block
`default_nettype none
`include "interval_rtc_consts.vh"
module interval_rtc_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, psel, penable, pwrite, lfc;
   logic [13:0] paddr;
   logic [31:0] pwdata, q;
   logic [2:0] fz;
   logic [1:0] ph;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, interval_irq, irq;
   int err_total, n_tests, c;
   interval_rtc dut
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .low_freq_clk(lfc),
      .low_freq_osc_enable(!fz[0]), .stop_mode(fz[1]),
      .deep_sleep_zero(fz[2]), .interval_irq(interval_irq), .irq(irq)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Slow clock, 8 system cycles a period
   always @(posedge ref_clk)
   begin
      ph <= ph + 2'h1;
      if (ph == 2'h3)
         lfc <= ~lfc;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task acc(input logic w, input logic [13:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [13:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task until_pulse();
      c = 0;
      do
      begin
         @(negedge ref_clk);
         c++;
      end
      while (interval_irq !== 1'b1 && c < 40000);
      if (c >= 40000)
         err_total++;
   endtask
   task results();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      {rst_n, psel, penable, pwrite, lfc, ph, fz} = 10'h000;
      paddr = 14'h0000;
      pwdata = 32'h0;
      err_total = 0;
      n_tests = 0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd(`ADDR_GATE, 32'h0);
      chk(pslverr, 1'b0);
      acc(1'b1, `ADDR_CTRL, 32'h0000_000f);
      acc(1'b1, 14'h3f24, 32'h0000_000f);
      rd(`ADDR_CTRL, 32'h0);
      acc(1'b1, `ADDR_GATE, 32'h0000_0020);
      rd(`ADDR_GATE, 32'h0000_0020);
      for (int n = 0; n < 8; n++)
      begin
         acc(1'b1, `ADDR_CTRL, 32'(2 * n + 1));
         rd(`ADDR_CTRL, 32'(2 * n + 1));
         acc(1'b1, `ADDR_CTRL, 32'(15 - 2 * n));
         rd(`ADDR_CTRL, 32'(2 * n + 1));
         acc(1'b1, `ADDR_CTRL, 32'(14 - 2 * n));
         rd(`ADDR_CTRL, 32'(2 * n));
      end
      acc(1'b1, `ADDR_IRQ_ENABLE, 32'h1);
      acc(1'b1, `ADDR_CTRL, 32'h0000_000f);
      until_pulse();
      until_pulse();
      chk(c, 2048);
      rd(`ADDR_IRQ_STATUS, 32'h1);
      chk(irq, 1'b1);
      acc(1'b1, `ADDR_IRQ_ENABLE, 32'h0);
      @(negedge ref_clk);
      chk(irq, 1'b0);
      acc(1'b1, `ADDR_IRQ_CLEAR, 32'h1);
      rd(`ADDR_IRQ_STATUS, 32'h0);
      acc(1'b1, `ADDR_IRQ_ENABLE, 32'h1);
      acc(1'b1, `ADDR_CTRL, 32'h0);
      acc(1'b1, `ADDR_CTRL, 32'h0000_000d);
      until_pulse();
      until_pulse();
      chk(c, 4096);
      // Stop mid-period; a stale count would fire early
      repeat (2000) @(posedge ref_clk);
      acc(1'b1, `ADDR_CTRL, 32'h0);
      acc(1'b1, `ADDR_CTRL, 32'h0000_000d);
      until_pulse();
      chk(32'(c > 4088 && c < 4112), 32'h1);
      // Gate dropped only once stopped; control writes then refused
      acc(1'b1, `ADDR_CTRL, 32'h0);
      acc(1'b1, `ADDR_GATE, 32'h0);
      acc(1'b1, `ADDR_CTRL, 32'h0000_000f);
      rd(`ADDR_CTRL, 32'h0000_000c);
      acc(1'b1, `ADDR_GATE, 32'h0000_0020);
      for (int k = 0; k < 3; k++)
      begin
         acc(1'b1, `ADDR_CTRL, 32'h0000_000f);
         fz <= 3'(1 << k);
         repeat (10) @(posedge ref_clk);
         rd(`ADDR_CTRL, 32'h0000_000e);
         fz <= 3'h0;
         repeat (8) @(posedge ref_clk);
      end
      results();
   end
   initial
   begin
      #200000;
      err_total++;
      results();
   end
endmodule
bind interval_rtc interval_rtc_checker watch (.ref_clk, .rst_n, .psel,
   .penable, .pwrite, .paddr, .prdata, .low_freq_clk, .low_freq_osc_enable,
   .stop_mode, .deep_sleep_zero, .interval_irq, .irq);
`default_nettype wire
